// file: dv/acps_host.sv
// Purpose: Host serial master model
// Assumes: Device samples sdi on sclk rise
// Notes: sclk stands low between frames
`timescale 1ns/1ps
`default_nettype none
module acps_host (
  input wire logic ref_clk,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  // --------
  // Bit engine
  // --------
  initial begin
    sclk = 1'b0;
    sdi = 1'b1;
  end
  // Half period 16 cycles; sdo read before the rise
  task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge ref_clk) #1;
      sdi = tx[i];
      repeat (15) @(posedge ref_clk);
      #1 rx = {rx[22:0], sdo};
      sclk = 1'b1;
      repeat (16) @(posedge ref_clk);
      #1 sclk = 1'b0;
    end
    sdi = ~sdi;
  endtask : xfer
endmodule : acps_host
`default_nettype wire

// file: dv/acps_sequencer_bench.sv
// Purpose: Self-checking bench for acps_sequencer
// Assumes: Bench answers conversions and calibrations
// Notes: Random answer delays, fixed seed
`timescale 1ns/1ps
`default_nettype none
module acps_sequencer_bench;
  logic ref_clk, rst, sclk, sdi, sdo, multi_conversion_bit, loop_bit, wait_for_read_bit;
  logic conv_start, conv_logical_odd, conv_done, cal_start, cal_done, in_data_mode;
  logic [1:0] variant_sel;
  logic [3:0] depth_field, conv_logical_ch, fifo_rd_index, p;
  logic [2:0] conv_setup_entry, cal_type;
  logic [23:0] conv_result, rx;
  logic [3:0] ch_q[$];
  logic [2:0] cal_q[$];
  logic [23:0] res_q[$];
  logic [3:0] ptab[4] = '{4'h3, 4'h4, 4'h7, 4'h8};
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  acps_sequencer DUT (.ref_clk, .rst, .sclk, .sdi, .sdo, .variant_sel, .multi_conversion_bit, .loop_bit,
    .wait_for_read_bit, .depth_field, .conv_start, .conv_logical_ch, .conv_setup_entry, .conv_logical_odd,
    .conv_done, .conv_result, .cal_start, .cal_type, .cal_done, .in_data_mode, .fifo_rd_index);
  acps_host host (.ref_clk, .sclk, .sdi, .sdo);
  // --------
  // Clock, answers, helpers
  // --------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 50000) begin
      n_errors++;
      stop_test();
    end
  end
  always @(negedge ref_clk) begin
    if (conv_start === 1'b1) begin
      ch_q.push_back(conv_logical_ch);
      repeat ($urandom_range(20, 2)) @(posedge ref_clk);
      #1 conv_result = $urandom;
      conv_done = 1'b1;
      res_q.push_back(conv_result);
      @(posedge ref_clk) #1 conv_done = 1'b0;
    end
  end
  always @(negedge ref_clk) begin
    if (cal_start === 1'b1) begin
      cal_q.push_back(cal_type);
      repeat ($urandom_range(20, 2)) @(posedge ref_clk);
      #1 cal_done = 1'b1;
      @(posedge ref_clk) #1 cal_done = 1'b0;
    end
  end
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic setcfg(input logic [1:0] v, input logic m, l, w, input logic [3:0] d);
    @(posedge ref_clk) #1;
    variant_sel = v;
    multi_conversion_bit = m;
    loop_bit = l;
    wait_for_read_bit = w;
    depth_field = d;
  endtask : setcfg
  task automatic cmd(input logic [7:0] b);
    host.xfer({16'h0, b}, 8, rx);
  endtask : cmd
  task automatic wait_low();
    for (int k = 0; k < 3000 && sdo !== 1'b0; k++) @(negedge ref_clk);
    chk("flag", sdo, 0);
  endtask : wait_low
  task automatic read_words(input int n, input logic [7:0] flag);
    host.xfer({16'h0, flag}, 8, rx);
    repeat (n) begin
      host.xfer(24'h0, 24, rx);
      chk("word", rx, res_q.pop_front());
    end
  endtask : read_words
  task automatic single(input logic [3:0] ptr);
    cmd({1'b1, ptr, 3'h0});
    wait_low();
    chk("ptr", ch_q.pop_front(), ptr);
    read_words(1, 8'h00);
    chk("mode", in_data_mode, loop_bit);
  endtask : single
  task automatic refuse(input logic [7:0] b);
    cmd(b);
    repeat (300) @(negedge ref_clk);
    chk("starts", 24'(ch_q.size() + cal_q.size()), 0);
    chk("mode", in_data_mode, 0);
  endtask : refuse
  // --------
  // Main sequence
  // --------
  initial begin
    rst = 1'b1;
    {conv_done, cal_done, conv_result} = '0;
    {multi_conversion_bit, loop_bit, wait_for_read_bit, depth_field} = '0;
    variant_sel = 2'h2;
    void'($urandom(32'h87904F7D));
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      setcfg(2'h2, 1'b0, 1'b0, 1'($urandom), 4'($urandom));
      single(i == 0 ? 4'hF : i == 1 ? 4'h0 : 4'($urandom));
    end
    $display("single conversions done");
    for (int i = 0; i < 4; i++) begin
      setcfg(2'(i / 2), 1'b0, 1'b0, 1'b1, 4'h0);
      if (i % 2 == 1) refuse({1'b1, ptab[i], 3'h0});
      else single(ptab[i]);
    end
    refuse(8'h00);
    $display("pointer limits done");
    setcfg(2'h2, 1'b0, 1'b1, 1'b1, 4'h0);
    p = 4'($urandom);
    single(p);
    wait_low();
    chk("again", ch_q.pop_front(), p);
    read_words(1, 8'hFF);
    chk("loop exit", 24'(in_data_mode + ch_q.size()), 0);
    $display("loop done");
    for (int lp = 0; lp < 2; lp++) begin
      setcfg(2'h2, 1'b1, 1'(lp), 1'b1, 4'($urandom_range(3, 1)));
      cmd({1'b1, 4'($urandom), 3'h0});
      wait_low();
      for (int k = 0; k <= depth_field; k++) chk("order", ch_q.pop_front(), k);
      read_words(depth_field + 1, lp ? 8'hFF : 8'($urandom_range(1, 0) * 255));
      chk("multi exit", 24'(in_data_mode + ch_q.size()), 0);
      chk("rd index", fifo_rd_index, depth_field);
    end
    $display("multi done");
    for (int c = 1; c < 8; c++) begin
      cmd({1'b1, 4'($urandom), 3'(c)});
      repeat (40) @(negedge ref_clk);
      chk("cal flag", sdo, 0);
      chk("cal code", cal_q.pop_front(), c);
      chk("cal once", 24'(in_data_mode + cal_q.size() + ch_q.size()), 0);
    end
    $display("calibration done");
    stop_test();
  end
endmodule : acps_sequencer_bench
`default_nettype wire

// file: dv/acps_sequencer_monitor.sv
// Purpose: Port assertions for acps_sequencer
// Assumes: One clock domain, rst async high
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module acps_sequencer_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic [1:0] variant_sel,
  input wire logic multi_conversion_bit,
  input wire logic [3:0] depth_field,
  input wire logic conv_start,
  input wire logic [3:0] conv_logical_ch,
  input wire logic [2:0] conv_setup_entry,
  input wire logic conv_logical_odd,
  input wire logic conv_done,
  input wire logic cal_start,
  input wire logic cal_done,
  input wire logic in_data_mode
);
  // --------
  // Properties
  // --------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence cmd_quiet_s;
    !in_data_mode && !conv_start;
  endsequence
  sequence flag_low_s;
    !sdo [*2];
  endsequence
  AST_CONV_MAP: assert property (
    conv_start |-> conv_setup_entry == conv_logical_ch[3:1] && conv_logical_odd == conv_logical_ch[0])
    else $error("setup entry off pointer");
  AST_PTR_LIMIT: assert property (
    conv_start |-> conv_logical_ch <= (variant_sel == 2'h0 ? 4'h3 : variant_sel == 2'h1 ? 4'h7 : 4'hF))
    else $error("pointer above limit");
  AST_DEPTH: assert property (
    conv_start && multi_conversion_bit |-> conv_logical_ch <= depth_field) else $error("channel past depth");
  AST_CONV_MODE: assert property (
    conv_start |=> in_data_mode) else $error("no data mode");
  AST_CAL_CMD: assert property (
    cal_start |=> cmd_quiet_s [*4]) else $error("left command mode");
  AST_CAL_DONE: assert property (
    cal_done |=> !sdo) else $error("no flag after cal");
  AST_CONV_DONE: assert property (
    conv_done && !multi_conversion_bit |=> !sdo) else $error("no flag after conv");
  AST_FLAG_HOLD: assert property (
    $fell(sdo) && !sclk |=> flag_low_s) else $error("sdo low too short");
endmodule : acps_sequencer_monitor
bind acps_sequencer acps_sequencer_monitor u_mon (.ref_clk, .rst, .sclk, .sdo, .variant_sel,
  .multi_conversion_bit, .depth_field, .conv_start, .conv_logical_ch, .conv_setup_entry,
  .conv_logical_odd, .conv_done, .cal_start, .cal_done, .in_data_mode);
`default_nettype wire

// file: hdl/acps_defines.svh
// Purpose: Constants for the command pointer sequencer
// Assumes: SCLK counted by edges found in the ref_clk domain
// Notes: Command byte is flag, pointer, code from MSB down
`ifndef ACPS_DEFINES_SVH
`define ACPS_DEFINES_SVH
`define ACPS_FLAG_POS 7
`define ACPS_PTR_HI 6
`define ACPS_PTR_LO 3
`define ACPS_CODE_HI 2
`define ACPS_CODE_LO 0
`define ACPS_CODE_CONV 3'h0
`define ACPS_CODE_SOFF 3'h5
`define ACPS_BYTE_ONES 8'hFF
`define ACPS_BYTE_ZERO 8'h00
`define ACPS_NULL_CMD 8'h00
`define ACPS_FLAG_SCLKS 6'h08
`define ACPS_WORD_SCLKS 6'h18
`define ACPS_VAR_16 2'h2
`define ACPS_VAR_8 2'h1
`define ACPS_VAR_4 2'h0
`define ACPS_MAX_PTR_16 4'hF
`define ACPS_MAX_PTR_8 4'h7
`define ACPS_MAX_PTR_4 4'h3
`endif

// file: hdl/acps_pkg.sv
// Purpose: Types for the command pointer sequencer
// Assumes: Nothing beyond the defines header
// Notes: States of the port sequencer
package acps_pkg;
  typedef enum logic [2:0] {
    ACPS_CMD = 3'h0,
    ACPS_CAL = 3'h1,
    ACPS_CONV = 3'h2,
    ACPS_WAIT_FLAG = 3'h3,
    ACPS_FLAG = 3'h4,
    ACPS_READ = 3'h5
  } acps_state_type;
endpackage : acps_pkg

// file: hdl/acps_sequencer.sv
// Purpose: Command byte interpreter and conversion/calibration sequencer
// Assumes: Host is SPI master; SCLK idles low, data sampled on rising edge
// Notes: Analog work is outside; done pulses come back on ports
`timescale 1ns/1ps
`default_nettype none
`include "acps_defines.svh"
module acps_sequencer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  input wire logic [1:0] variant_sel,
  input wire logic multi_conversion_bit,
  input wire logic loop_bit,
  input wire logic wait_for_read_bit,
  input wire logic [3:0] depth_field,
  output logic conv_start,
  output logic [3:0] conv_logical_ch,
  output logic [2:0] conv_setup_entry,
  output logic conv_logical_odd,
  input wire logic conv_done,
  input wire logic [23:0] conv_result,
  output logic cal_start,
  output logic [2:0] cal_type,
  input wire logic cal_done,
  output logic in_data_mode,
  output logic [3:0] fifo_rd_index
);
  import acps_pkg::*;

  // ----------------------------------------
  // Link sampling
  // ----------------------------------------
  logic sclk_s;
  logic sclk_rise;
  logic sdi_s;
  logic sdi_meta_ff;
  logic sdi_ff;
  acps_sync u_sclk_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(sclk),
    .sync_out(sclk_s),
    .rise_out(sclk_rise)
  );
  // Data delayed to match the clock path so it lines up with the edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sdi_meta_ff <= 1'b0;
      sdi_ff <= 1'b0;
    end else begin
      sdi_meta_ff <= sdi;
      sdi_ff <= sdi_meta_ff;
    end
  end
  assign sdi_s = sdi_ff;

  // ----------------------------------------
  // State
  // ----------------------------------------
  acps_state_type state_ff;
  logic [7:0] shift_ff;
  logic [2:0] bit_cnt_ff;
  logic [5:0] sclk_cnt_ff;
  logic [3:0] ptr_ff;
  logic [3:0] conv_idx_ff;
  logic [3:0] rd_idx_ff;
  logic exit_ff;
  logic multi_ff;
  logic loop_ff;
  logic rwait_ff;
  logic sdo_ff;
  logic [23:0] out_sh_ff;
  logic [23:0] fifo_ff [0:15];
  logic [3:0] max_ptr;
  logic [7:0] cmd_byte;
  logic byte_done;
  logic [3:0] last_idx;
  logic bg_busy_ff;

  assign cmd_byte = {shift_ff[6:0], sdi_s};
  assign byte_done = sclk_rise && (bit_cnt_ff == 3'h7);
  assign last_idx = multi_ff ? depth_field : 4'h0;

  always_comb begin
    case (variant_sel)
      `ACPS_VAR_16: max_ptr = `ACPS_MAX_PTR_16;
      `ACPS_VAR_8: max_ptr = `ACPS_MAX_PTR_8;
      default: max_ptr = `ACPS_MAX_PTR_4;
    endcase
  end

  // ----------------------------------------
  // Command byte assembly
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
    end else begin
      // Shifts in every state so the flag-clearing byte is seen too
      if (sclk_rise) begin
        shift_ff <= cmd_byte;
      end
      if (state_ff != ACPS_CMD && state_ff != ACPS_CAL) begin
        bit_cnt_ff <= 3'h0;
      end else if (sclk_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ACPS_CMD;
      ptr_ff <= 4'h0;
      conv_idx_ff <= 4'h0;
      rd_idx_ff <= 4'h0;
      sclk_cnt_ff <= 6'h00;
      exit_ff <= 1'b0;
      multi_ff <= 1'b0;
      loop_ff <= 1'b0;
      rwait_ff <= 1'b0;
      sdo_ff <= 1'b1;
      out_sh_ff <= 24'h000000;
      conv_start <= 1'b0;
      cal_start <= 1'b0;
      cal_type <= 3'h0;
      bg_busy_ff <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      cal_start <= 1'b0;
      case (state_ff)
        ACPS_CMD: begin
          // Calibration flag stands until the host clocks again
          if (sclk_rise) begin
            sdo_ff <= 1'b1;
          end
          // Only flagged bytes act; the null byte leaves the port here
          if (byte_done && cmd_byte[`ACPS_FLAG_POS]) begin
            if (cmd_byte[`ACPS_CODE_HI:`ACPS_CODE_LO] == `ACPS_CODE_CONV) begin
              multi_ff <= multi_conversion_bit;
              loop_ff <= loop_bit;
              rwait_ff <= wait_for_read_bit;
              exit_ff <= 1'b0;
              if (multi_conversion_bit) begin
                ptr_ff <= 4'h0;
                conv_idx_ff <= 4'h0;
                conv_start <= 1'b1;
                state_ff <= ACPS_CONV;
              end else if (cmd_byte[`ACPS_PTR_HI:`ACPS_PTR_LO] <= max_ptr) begin
                ptr_ff <= cmd_byte[`ACPS_PTR_HI:`ACPS_PTR_LO];
                conv_idx_ff <= 4'h0;
                conv_start <= 1'b1;
                state_ff <= ACPS_CONV;
              end
            end else if (cmd_byte[`ACPS_PTR_HI:`ACPS_PTR_LO] <= max_ptr) begin
              ptr_ff <= cmd_byte[`ACPS_PTR_HI:`ACPS_PTR_LO];
              cal_type <= cmd_byte[`ACPS_CODE_HI:`ACPS_CODE_LO];
              cal_start <= 1'b1;
              state_ff <= ACPS_CAL;
            end
          end
        end
        ACPS_CAL: begin
          // Port stays in command mode; further bytes are ignored meanwhile
          if (cal_done) begin
            sdo_ff <= 1'b0;
            state_ff <= ACPS_CMD;
          end
        end
        ACPS_CONV: begin
          if (conv_done) begin
            if (conv_idx_ff == last_idx) begin
              sdo_ff <= 1'b0;
              state_ff <= ACPS_FLAG;
              sclk_cnt_ff <= 6'h00;
              rd_idx_ff <= 4'h0;
              // Word zero is still in flight when only one channel runs
              out_sh_ff <= (conv_idx_ff == 4'h0) ? conv_result : fifo_ff[0];
            end else begin
              conv_idx_ff <= conv_idx_ff + 4'h1;
              ptr_ff <= ptr_ff + 4'h1;
              conv_start <= 1'b1;
            end
          end
        end
        ACPS_FLAG: begin
          if (sclk_rise) begin
            sdo_ff <= 1'b1;
            sclk_cnt_ff <= sclk_cnt_ff + 6'h01;
            if (sclk_cnt_ff == `ACPS_FLAG_SCLKS - 6'h01) begin
              // Ones anywhere but all-ones count as stay; a partial byte is not an exit
              exit_ff <= (cmd_byte == `ACPS_BYTE_ONES) || !loop_ff;
              state_ff <= ACPS_READ;
              sclk_cnt_ff <= 6'h00;
              sdo_ff <= out_sh_ff[23];
              // Free-running repeat restarts background work at once in multi-channel mode only
              if (loop_ff && !rwait_ff && cmd_byte != `ACPS_BYTE_ONES) begin
                conv_idx_ff <= 4'h0;
                ptr_ff <= 4'h0;
                bg_busy_ff <= multi_ff;
                conv_start <= !multi_ff ? 1'b0 : 1'b1;
              end
            end
          end
        end
        ACPS_READ: begin
          if (bg_busy_ff && conv_done) begin
            conv_idx_ff <= conv_idx_ff + 4'h1;
            ptr_ff <= ptr_ff + 4'h1;
            bg_busy_ff <= conv_idx_ff != last_idx;
            conv_start <= conv_idx_ff != last_idx;
          end
          if (sclk_rise) begin
            sclk_cnt_ff <= sclk_cnt_ff + 6'h01;
            out_sh_ff <= {out_sh_ff[22:0], 1'b0};
            sdo_ff <= out_sh_ff[22];
            if (sclk_cnt_ff == `ACPS_WORD_SCLKS - 6'h01) begin
              sclk_cnt_ff <= 6'h00;
              if (rd_idx_ff != last_idx) begin
                rd_idx_ff <= rd_idx_ff + 4'h1;
                out_sh_ff <= fifo_ff[rd_idx_ff + 4'h1];
                sdo_ff <= fifo_ff[rd_idx_ff + 4'h1][23];
              end else if (exit_ff) begin
                sdo_ff <= 1'b1;
                state_ff <= ACPS_CMD;
              end else begin
                sdo_ff <= 1'b1;
                conv_idx_ff <= 4'h0;
                if (multi_ff) begin
                  ptr_ff <= 4'h0;
                end
                if (!bg_busy_ff) begin
                  conv_start <= 1'b1;
                end
                state_ff <= ACPS_CONV;
              end
            end
          end
        end
        default: begin
          state_ff <= ACPS_CMD;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Result FIFO
  // ----------------------------------------
  // Written at each conversion end; old set is overwritten in free-running repeat
  always_ff @(posedge ref_clk) begin
    if (conv_done && (state_ff == ACPS_CONV || bg_busy_ff)) begin
      fifo_ff[conv_idx_ff] <= conv_result;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sdo = sdo_ff;
  assign conv_logical_ch = ptr_ff;
  assign conv_setup_entry = ptr_ff[3:1];
  assign conv_logical_odd = ptr_ff[0];
  assign in_data_mode = (state_ff != ACPS_CMD) && (state_ff != ACPS_CAL);
  assign fifo_rd_index = rd_idx_ff;
  // Offset/gain storage per physical channel lives outside, keyed by entry
endmodule : acps_sequencer
`default_nettype wire

// file: hdl/acps_sync.sv
// Purpose: Two-flop synchroniser with edge finder behind it
// Assumes: Input is asynchronous to ref_clk
// Notes: First flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module acps_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out,
  output logic rise_out
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end
  assign sync_out = sync_ff;
  assign rise_out = sync_ff & ~last_ff;
endmodule : acps_sync
`default_nettype wire
